//--- rtl/hps_pkg.sv
// Constants and types for the hot-plug port select block
// Behaviour
// R1 - Both sink hot-plug lows: low power, switched outputs off, circuitry shut down.
// R2 - One sink hot-plug rising from both-low selects that input's port.
// R3 - Both sink hot-plug inputs high: priority input picks the port.
// R4 - Low-power control low: select port, repeat hot-plug, keep link I/O off.
// R5 - Low-power control high: leave low power, enable link I/O, repeat hot-plug.
// R6 - Selected port low pulses repeat to source with equal width, small delay.
// R7 - Lone input low past unplug time counts as unplug, enter low power.
// R8 - Both high, selected low past unplug time: switch to other port.
// R9 - Priority port selected: non-priority hot-plug activity ignored.
// R10 - Priority port rising while other selected forces source output low.
// R11 - Priority input low pulse during forced low restarts the timer.
// R12 - Forced low done: switch to priority port, then follow its input.
// R13 - Never select a low port; priority ignored with one input high.
// R14 - Both high, priority change: settle pause, then forced low and switch.
// R15 - Unplug simulation time lies between 170 and 400 ms.
// R16 - Priority settle pause lies between 2 and 4.7 ms.
// R17 - Low pulses of at least 100 ns are repeated.
// R18 - Timing counts the clock; power-up in low power, no port selected.
package hps_pkg;
  localparam int CLK_MHZ = 200;
  // Unplug time taken as 200 ms, inside its window
  localparam int UNPLUG_SIM_TIME_MS = 200;
  localparam int UNPLUG_SIM_CYCLES = UNPLUG_SIM_TIME_MS * 1000 * CLK_MHZ;
  // Settle pause taken as 3 ms, inside its window
  localparam int PRIORITY_SETTLE_TIME_US = 3000;
  localparam int PRIORITY_SETTLE_CYCLES = PRIORITY_SETTLE_TIME_US * CLK_MHZ;
  localparam int MIN_REPEAT_PULSE_TIME_NS = 100;
  localparam int MIN_REPEAT_PULSE_CYCLES = (MIN_REPEAT_PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 32;

  typedef enum logic [4:0] {
    HPS_IDLE = 5'h01,
    HPS_RUN = 5'h02,
    HPS_SETTLE = 5'h04,
    HPS_FORCE = 5'h08,
    HPS_LOST = 5'h10
  } hps_state_e;

  typedef struct packed {
    logic port_one;
    logic port_two;
  } hps_hpd_s;

  typedef struct packed {
    logic sel_valid;
    logic sel_two;
    logic link_en;
    logic active;
  } hps_stat_s;
endpackage : hps_pkg

//--- rtl/hps_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module hps_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_cfg
    $error("hps_sync: width must be at least one");
  end

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = ce ? d : meta_ff;
    nxt_q = ce ? meta_ff : q_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : hps_sync
`default_nettype wire

//--- rtl/hps_port_select.sv
// Hot-plug port selection and repeating for a one-to-two link switch
`timescale 1ns/1ps
`default_nettype none
module hps_port_select
  import hps_pkg::*;
#(
  parameter int UNPLUG_CYCLES = UNPLUG_SIM_CYCLES,
  parameter int SETTLE_CYCLES = PRIORITY_SETTLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins
  input wire hps_hpd_s sink_hotplug,
  input wire logic priority_two,
  input wire logic low_power_control,
  // Source hot-plug out
  output logic src_hotplug,
  output logic src_hotplug_oe,
  // Link enables
  output logic link_en_one,
  output logic link_en_two,
  output logic core_awake,
  // Status
  output var hps_stat_s status
);
  // Settle pause must be shorter than the unplug time
  if (UNPLUG_CYCLES < 2 || SETTLE_CYCLES < 1 || SETTLE_CYCLES >= UNPLUG_CYCLES) begin : g_cfg
    $error("hps_port_select: timer counts unusable");
  end

  logic [3:0] pins;
  logic h1, h2, pri, lpc;

  // Pins cross into clk here; no logic below reads a raw pin
  hps_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({sink_hotplug.port_one, sink_hotplug.port_two, priority_two, low_power_control}),
    .q(pins)
  );

  // Bit order follows the concatenation into the synchroniser
  assign h1 = pins[3];
  assign h2 = pins[2];
  assign pri = pins[1];
  assign lpc = pins[0];

  // State, port choice and timers
  hps_state_e state_ff, nxt_state;
  logic sel_two_ff, nxt_sel_two;
  logic [TMR_W-1:0] tmr_ff, nxt_tmr;
  // Priority port low time while forcing; a long low keeps the old port
  logic [TMR_W-1:0] plow_ff, nxt_plow;
  logic pri_ff, nxt_pri;
  logic h1_d_ff, h2_d_ff;
  logic src_ff, nxt_src;
  logic oe_ff, nxt_oe;
  logic en1_ff, en2_ff, awake_ff, nxt_en1, nxt_en2, nxt_awake;
  hps_stat_s stat_ff, nxt_stat;

  // Level of port two when two is set, else port one
  function automatic logic hpd_of(input logic two, input logic a, input logic b);
    hpd_of = two ? b : a;
  endfunction : hpd_of

  // Priority port rise, against last cycle's levels
  logic sel_hpd, oth_hpd, pri_hpd, pri_rise;
  always_comb begin
    sel_hpd = hpd_of(sel_two_ff, h1, h2);
    oth_hpd = hpd_of(!sel_two_ff, h1, h2);
    pri_hpd = hpd_of(pri, h1, h2);
    pri_rise = pri_hpd && !hpd_of(pri, h1_d_ff, h2_d_ff);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_sel_two = sel_two_ff;
    nxt_tmr = tmr_ff;
    nxt_pri = pri;
    nxt_plow = '0;
    case (state_ff)
      HPS_IDLE: begin
        nxt_tmr = '0;
        // Both up at once: priority decides
        if (h1 && h2) begin
          nxt_sel_two = pri; // R3
          nxt_state = HPS_RUN;
        end else if (h1 || h2) begin
          nxt_sel_two = h2; // R2
          nxt_state = HPS_RUN;
        end
      end
      HPS_RUN: begin
        nxt_tmr = '0;
        // First low cycle already counts toward the unplug time
        if (!sel_hpd) begin
          nxt_tmr = TMR_W'(1);
          nxt_state = HPS_LOST;
        end else if (oth_hpd && (pri != pri_ff)) begin
          nxt_state = HPS_SETTLE; // R14
        end else if (oth_hpd && (sel_two_ff != pri) && pri_rise) begin
          nxt_state = HPS_FORCE; // R10
        end
        // R9 R13
      end
      HPS_SETTLE: begin
        nxt_tmr = tmr_ff + TMR_W'(1);
        // Each priority change restarts the pause, so glitches die here
        if (pri != pri_ff) begin
          nxt_tmr = '0;
        end else if (!(h1 && h2)) begin
          nxt_tmr = '0;
          nxt_state = HPS_RUN;
        end else if (tmr_ff >= TMR_W'(SETTLE_CYCLES - 1)) begin
          nxt_tmr = '0;
          nxt_state = (sel_two_ff != pri) ? HPS_FORCE : HPS_RUN; // R16
        end
      end
      HPS_FORCE: begin
        // Old port stays selected while the source sees a long low
        nxt_tmr = tmr_ff + TMR_W'(1);
        if (!pri_hpd) begin
          nxt_tmr = '0; // R11
          nxt_plow = plow_ff + TMR_W'(1);
          if (!sel_hpd) begin
            nxt_state = HPS_LOST;
          end else if (plow_ff >= TMR_W'(UNPLUG_CYCLES - 1)) begin
            // Priority port unplugged, not pulsing: else the force never ends
            nxt_state = HPS_RUN; // R13
          end
        end else if (tmr_ff >= TMR_W'(UNPLUG_CYCLES - 1)) begin
          nxt_tmr = '0;
          nxt_sel_two = pri; // R12 R15
          nxt_state = HPS_RUN;
        end
      end
      HPS_LOST: begin
        // Short lows come back to run; long ones unplug or move
        nxt_tmr = tmr_ff + TMR_W'(1);
        if (sel_hpd) begin
          nxt_tmr = '0; // R6
          nxt_state = HPS_RUN;
        end else if (tmr_ff >= TMR_W'(UNPLUG_CYCLES - 1)) begin
          nxt_tmr = '0;
          // Other port still up: move to it instead of sleeping
          if (oth_hpd) begin
            nxt_sel_two = !sel_two_ff; // R8
            nxt_state = HPS_RUN;
          end else begin
            nxt_state = HPS_IDLE; // R7
          end
        end
      end
      default: begin
        nxt_state = HPS_IDLE;
      end
    endcase
  end

  // Outputs decode the next state so they land with it
  always_comb begin
    nxt_oe = (nxt_state != HPS_IDLE); // R1
    nxt_src = 1'b0;
    if (nxt_state == HPS_RUN || nxt_state == HPS_SETTLE || nxt_state == HPS_LOST) begin
      nxt_src = hpd_of(nxt_sel_two, h1, h2); // R6 R17
    end
    // Link I/O only when allowed out of low power; one port at a time
    nxt_awake = nxt_oe && lpc; // R5
    nxt_en1 = nxt_awake && !nxt_sel_two; // R4
    nxt_en2 = nxt_awake && nxt_sel_two;
    nxt_stat.sel_valid = nxt_oe;
    nxt_stat.sel_two = nxt_sel_two && nxt_oe;
    nxt_stat.link_en = nxt_awake;
    nxt_stat.active = (nxt_state != HPS_IDLE) && (nxt_state != HPS_LOST);
  end

  // Everything freezes while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= HPS_IDLE; // R18
      sel_two_ff <= 1'b0;
      tmr_ff <= '0;
      pri_ff <= 1'b0;
      h1_d_ff <= 1'b0;
      h2_d_ff <= 1'b0;
      src_ff <= 1'b0;
      oe_ff <= 1'b0;
      en1_ff <= 1'b0;
      en2_ff <= 1'b0;
      awake_ff <= 1'b0;
      stat_ff <= '0;
      plow_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      sel_two_ff <= nxt_sel_two;
      tmr_ff <= nxt_tmr;
      pri_ff <= nxt_pri;
      h1_d_ff <= h1;
      h2_d_ff <= h2;
      src_ff <= nxt_src;
      oe_ff <= nxt_oe;
      en1_ff <= nxt_en1;
      en2_ff <= nxt_en2;
      awake_ff <= nxt_awake;
      stat_ff <= nxt_stat;
      plow_ff <= nxt_plow;
    end
  end

  // Every output straight from a flop
  assign src_hotplug = src_ff;
  assign src_hotplug_oe = oe_ff;
  assign link_en_one = en1_ff;
  assign link_en_two = en2_ff;
  assign core_awake = awake_ff;
  assign status = stat_ff;
endmodule : hps_port_select
`default_nettype wire

//--- tb/hps_port_select_sva.sv
// Assertion checker for the hot-plug port select block
`timescale 1ns/1ps
`default_nettype none
module hps_port_select_sva
  import hps_pkg::*;
#(
  parameter int UNPLUG_CYCLES = 50,
  parameter int SETTLE_CYCLES = 10
) (
  // Clock and pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire hps_hpd_s sink_hotplug,
  input wire logic priority_two,
  input wire logic low_power_control,
  // Block outputs
  input wire logic src_hotplug,
  input wire logic src_hotplug_oe,
  input wire logic link_en_one,
  input wire logic link_en_two,
  input wire logic core_awake,
  input wire hps_stat_s status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Consecutive cycles with the source output driven low
  logic [31:0] low_cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_ff <= '0;
    end else if (ce) begin
      low_cnt_ff <= (src_hotplug_oe && !src_hotplug) ? low_cnt_ff + 32'h1 : 32'h0;
    end
  end
  switch_time_a:
    assert property (status.sel_valid && $past(status.sel_valid) && $changed(status.sel_two)
      |-> low_cnt_ff >= UNPLUG_CYCLES - 1)
    else $error("port switched before the unplug time");
  lp_gate_a:
    assert property ((link_en_one || link_en_two) |-> $past(low_power_control, 3))
    else $error("link enabled while low power requested");
  idle_off_a:
    assert property (!src_hotplug_oe |-> !(link_en_one || link_en_two || core_awake))
    else $error("link enabled while idle");
  awake_oe_a:
    assert property (core_awake |-> src_hotplug_oe && status.link_en)
    else $error("awake without source output");
  port_link_a:
    assert property ((link_en_one || link_en_two) |-> link_en_two == status.sel_two)
    else $error("link enable on wrong port");
  oe_sel_a:
    assert property (src_hotplug_oe == status.sel_valid)
    else $error("source output enable differs from selection");
  repeat_src_a:
    assert property (src_hotplug |->
      (status.sel_two ? $past(sink_hotplug.port_two, 3) : $past(sink_hotplug.port_one, 3)))
    else $error("source high without selected input");
  sel_high_a:
    assert property ($rose(status.sel_valid) |->
      (status.sel_two ? $past(sink_hotplug.port_two, 3) : $past(sink_hotplug.port_one, 3)))
    else $error("low port selected");
  switch_low_a:
    assert property (status.sel_valid && $past(status.sel_valid) && $changed(status.sel_two)
      |-> !$past(src_hotplug) && !$past(src_hotplug, 8))
    else $error("port switched without low source output");
  idle_after_a:
    assert property ($fell(src_hotplug_oe) |-> !$past(src_hotplug, 8))
    else $error("idle entered without long low");
endmodule : hps_port_select_sva
`default_nettype wire

//--- tb/hps_sink_model.sv
// Two sink ports driving hot-plug levels on command
`timescale 1ns/1ps
`default_nettype none
module hps_sink_model
  import hps_pkg::*;
(
  // Plug command, port one in the upper bit
  input wire logic [1:0] plug,
  // Hot-plug pins
  output var hps_hpd_s hpd
);
  // Sinks hold their pins as plain levels, never released
  assign hpd = '{port_one: plug[1], port_two: plug[0]};
endmodule : hps_sink_model
`default_nettype wire

//--- tb/test_hotplug_port_select.sv
// Self-checking bench for the hot-plug port select block
`timescale 1ns/1ps
`default_nettype none
module test_hotplug_port_select
  import hps_pkg::*;
;
  localparam int UNPLUG = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] plug = 2'h0;
  logic prio = 1'b0;
  logic lpc = 1'b0;
  hps_hpd_s hpd;
  logic src, oe, le1, le2, awake;
  hps_stat_s st;
  int failures = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  hps_sink_model sink (.plug(plug), .hpd(hpd));
  hps_port_select #(.UNPLUG_CYCLES(UNPLUG), .SETTLE_CYCLES(10)) dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .sink_hotplug(hpd), .priority_two(prio),
    .low_power_control(lpc), .src_hotplug(src), .src_hotplug_oe(oe), .link_en_one(le1),
    .link_en_two(le2), .core_awake(awake), .status(st));
  task automatic drive(input logic [1:0] p, input int n);
    plug = p;
    repeat (n) @(negedge clk);
  endtask : drive
  // core_awake is expected to match the expected link enable bit
  task automatic chk(input logic [7:0] exp);
    logic [8:0] got;
    got = {awake, oe, src, le2, le1, st};
    cmp_count++;
    if (got !== {exp[1], exp}) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, {exp[1], exp});
    end
  endtask : chk
  task automatic final_report;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic low_power_pick;
    drive(2'h2, 4);
    chk(8'hc9);
    drive(2'h0, UNPLUG + 10);
    chk(8'h00);
  endtask : low_power_pick
  task automatic wake_and_pulse;
    lpc = 1'b1;
    drive(2'h2, 4);
    chk(8'hdb);
    drive(2'h0, 4);
    chk(8'h9a);
    drive(2'h2, 4);
    chk(8'hdb);
  endtask : wake_and_pulse
  task automatic priority_takeover;
    prio = 1'b1;
    drive(2'h2, 8);
    chk(8'hdb);
    drive(2'h3, 30);
    chk(8'h9b);
    drive(2'h2, 2);
    drive(2'h3, 40);
    chk(8'h9b);
    drive(2'h3, 30);
    chk(8'hef);
  endtask : priority_takeover
  task automatic priority_toggle;
    prio = 1'b0;
    drive(2'h3, 8);
    chk(8'hef);
    drive(2'h3, 70);
    chk(8'hdb);
    drive(2'h2, 5);
    chk(8'hdb);
    drive(2'h3, 5);
    chk(8'hdb);
  endtask : priority_toggle
  task automatic unplug_moves;
    drive(2'h1, UNPLUG + 10);
    chk(8'hef);
    drive(2'h0, UNPLUG + 10);
    chk(8'h00);
  endtask : unplug_moves
  // Priority port goes away for good while the old port is forced low
  task automatic priority_gone;
    drive(2'h1, 8);
    chk(8'hef);
    drive(2'h3, 8);
    chk(8'haf);
    drive(2'h1, UNPLUG + 10);
    chk(8'hef);
  endtask : priority_gone
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    drive(2'h0, 2);
    chk(8'h00);
    low_power_pick();
    wake_and_pulse();
    priority_takeover();
    priority_toggle();
    unplug_moves();
    priority_gone();
    final_report();
  end
  // Hang guard, far beyond the longest sequence
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : test_hotplug_port_select
bind hps_port_select hps_port_select_sva #(.UNPLUG_CYCLES(UNPLUG_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.clk(clk), .rst_n(rst_n), .ce(ce),
  .sink_hotplug(sink_hotplug), .priority_two(priority_two),
  .low_power_control(low_power_control), .src_hotplug(src_hotplug),
  .src_hotplug_oe(src_hotplug_oe), .link_en_one(link_en_one), .link_en_two(link_en_two),
  .core_awake(core_awake), .status(status));
`default_nettype wire
